// >>> rtl/swr_device.sv
// Purpose: single-wire symbol receiver, lock register and acknowledge
// Assumes: line is asynchronous to MCLK
// Notes: frame = delimiter then 24 bits; byte 2 selects target
//
// Overview of operation
// - accept symbol rates 0.3 to 19.2 kHz
// - delimiter high time 7/16 to 9/16
// - zero high time 3/16 to 5/16
// - one high time 11/16 to 13/16
// - ack asserts 1/4 period after reference
// - ack releases 7/4 period after reference
// - timeout timer of nominally 100 ms
// - key 0x95 unlocks configuration registers
// - any other lock value relocks configuration
// - converter code updates only while locked
// - ack_en set: acknowledge each valid frame
// - valid frame clears error condition
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`include "swr_defs.svh"
module swr_device #(
  parameter int unsigned TIMEOUT_CYC = `SWR_TIMEOUT_CYC // timer length in cycles
) (
  input wire logic MCLK, // 20 MHz clock
  input wire logic ARST_N, // async reset, active low
  swr_link_if.dev LINK, // symbol line and ack
  output logic [15:0] DAC_CODE, // converter code
  output logic FAULT_FLAG, // error condition, high
  output logic INPUT_ECHO, // filtered line echo
  output logic CFG_UNLOCKED // configuration unlocked
);

  // ==========================================================
  // classification
  function automatic swr_pkg::swr_sym_t classify(input logic [17:0] p, input logic [17:0] h);
    logic [21:0] h16;
    logic [21:0] pp;
    h16 = {h, 4'h0};
    pp = {4'h0, p};
    if (p < 18'(`SWR_PER_MIN_CYC) || p > 18'(`SWR_PER_MAX_CYC)) begin
      return swr_pkg::SYM_NONE;
    end
    if (h16 >= pp * 22'(`SWR_DELIM_LO) && h16 <= pp * 22'(`SWR_DELIM_HI)) begin
      return swr_pkg::SYM_DELIM;
    end
    if (h16 >= pp * 22'(`SWR_ZERO_LO) && h16 <= pp * 22'(`SWR_ZERO_HI)) begin
      return swr_pkg::SYM_ZERO;
    end
    if (h16 >= pp * 22'(`SWR_ONE_LO) && h16 <= pp * 22'(`SWR_ONE_HI)) begin
      return swr_pkg::SYM_ONE;
    end
    return swr_pkg::SYM_NONE;
  endfunction : classify

  // ==========================================================
  // state
  logic [2:0] sync_q, sync_d;
  logic din_q, din_d;
  logic [17:0] per_q, per_d;
  logic [17:0] hi_q, hi_d;
  swr_pkg::swr_rx_state_t state_q, state_d;
  logic [4:0] bits_q, bits_d;
  logic [23:0] word_q, word_d;
  logic [7:0] lock_q, lock_d;
  logic [4:0] cfg2_q, cfg2_d;
  logic [15:0] code_q, code_d;
  logic err_q, err_d;
  logic [20:0] to_q, to_d;
  logic ack_run_q, ack_run_d;
  logic ack_q, ack_d;
  logic [21:0] ack_cnt_q, ack_cnt_d;
  logic [17:0] ack_per_q, ack_per_d;
  logic unlocked_q, unlocked_d;

  logic rise;
  logic fall;
  logic frame_ok;
  logic to_hit;
  logic unlocked;
  logic [23:0] new_word;
  logic [21:0] on_cyc;
  logic [21:0] off_cyc;
  logic [1:0] serr;
  swr_pkg::swr_sym_t sym;

  // ==========================================================
  // next-state logic
  always_comb begin
    // first stage feeds only the second; second and third must agree
    sync_d = {sync_q[1:0], LINK.line};
    din_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : din_q;
    rise = din_d & ~din_q;
    fall = ~din_d & din_q;

    // period since last rise, high time latched at fall; saturate when idle
    per_d = rise ? 18'h00001 : ((per_q == 18'h3ffff) ? per_q : per_q + 18'h00001);
    hi_d = fall ? per_q : hi_q;
    sym = classify(per_q, hi_q);

    unlocked = (lock_q == `SWR_KEY);
    state_d = state_q;
    bits_d = bits_q;
    word_d = word_q;
    frame_ok = 1'b0;
    new_word = {word_q[22:0], (sym == swr_pkg::SYM_ONE)};
    to_hit = (to_q == 21'(TIMEOUT_CYC - 1));

    if (rise) begin
      case (sym)
        swr_pkg::SYM_DELIM: begin
          state_d = swr_pkg::RX_BITS;
          bits_d = 5'h00;
        end
        swr_pkg::SYM_ZERO, swr_pkg::SYM_ONE: begin
          if (state_q == swr_pkg::RX_BITS) begin
            word_d = new_word;
            bits_d = bits_q + 5'h01;
            if (bits_q == 5'(`SWR_FRAME_BITS - 1)) begin
              frame_ok = 1'b1;
              state_d = swr_pkg::RX_HUNT;
            end
          end
        end
        default: begin
          // out-of-band symbol: drop the partial frame and wait for a delimiter
          state_d = swr_pkg::RX_HUNT;
        end
      endcase
    end
    if (to_hit) begin
      state_d = swr_pkg::RX_HUNT;
    end

    // register updates carried by a completed frame
    lock_d = lock_q;
    cfg2_d = cfg2_q;
    code_d = code_q;
    serr = 2'h0;
    err_d = err_q;
    if (frame_ok) begin
      err_d = 1'b0;
      case (new_word[23:16])
        `SWR_REG_LOCK: begin
          lock_d = new_word[7:0];
        end
        `SWR_REG_CFG1: begin
          if (unlocked) begin
            serr = new_word[`SWR_CFG1_SERR_LSB +: 2];
            if (new_word[`SWR_CFG1_RST_BIT]) begin
              lock_d = `SWR_LOCK_RST;
              cfg2_d = `SWR_CFG2_RST;
              code_d = `SWR_CODE_RST;
              serr = `SWR_SERR_SET;
            end
          end
        end
        `SWR_REG_CFG2: begin
          if (unlocked) begin
            cfg2_d = new_word[4:0];
          end
        end
        `SWR_REG_CODE: begin
          if (!unlocked) begin
            code_d = new_word[15:0];
          end
        end
        default: begin
          // unknown target: frame still counts as valid
        end
      endcase
    end
    // registered so the unlocked output comes straight from a flop
    unlocked_d = (lock_d == `SWR_KEY);
    if (serr == `SWR_SERR_CLR) begin
      err_d = 1'b0;
    end
    // a set arriving with a clear wins
    if (serr == `SWR_SERR_SET || (to_hit && cfg2_q[`SWR_CFG2_CHAN_BIT])) begin
      err_d = 1'b1;
    end

    // timeout restarts on every valid frame and wraps after firing
    to_d = (frame_ok || to_hit) ? 21'h000000 : to_q + 21'h000001;

    // acknowledge window timed from the rise that completed the frame
    on_cyc = 22'(({4'h0, ack_per_q} * 22'(`SWR_ACK_ON_16THS)) >> 4);
    off_cyc = 22'(({4'h0, ack_per_q} * 22'(`SWR_ACK_OFF_16THS)) >> 4);
    ack_run_d = ack_run_q;
    ack_d = ack_q;
    ack_cnt_d = ack_cnt_q;
    ack_per_d = ack_per_q;
    if (frame_ok && cfg2_q[`SWR_CFG2_ACK_EN_BIT]) begin
      ack_run_d = 1'b1;
      ack_d = 1'b0;
      ack_cnt_d = 22'h000001;
      ack_per_d = per_q;
    end else if (ack_run_q) begin
      ack_cnt_d = ack_cnt_q + 22'h000001;
      if (ack_cnt_q == on_cyc) begin
        ack_d = 1'b1;
      end
      if (ack_cnt_q == off_cyc) begin
        ack_d = 1'b0;
        ack_run_d = 1'b0;
      end
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sync_q <= 3'h0;
      din_q <= 1'b0;
      per_q <= 18'h3ffff;
      hi_q <= 18'h00000;
      state_q <= swr_pkg::RX_HUNT;
      bits_q <= 5'h00;
      word_q <= 24'h000000;
      lock_q <= `SWR_LOCK_RST;
      cfg2_q <= `SWR_CFG2_RST;
      code_q <= `SWR_CODE_RST;
      err_q <= 1'b1;
      to_q <= 21'h000000;
      ack_run_q <= 1'b0;
      ack_q <= 1'b0;
      ack_cnt_q <= 22'h000000;
      ack_per_q <= 18'h00000;
      unlocked_q <= 1'b0;
    end else begin
      sync_q <= sync_d;
      din_q <= din_d;
      per_q <= per_d;
      hi_q <= hi_d;
      state_q <= state_d;
      bits_q <= bits_d;
      word_q <= word_d;
      lock_q <= lock_d;
      cfg2_q <= cfg2_d;
      code_q <= code_d;
      err_q <= err_d;
      to_q <= to_d;
      ack_run_q <= ack_run_d;
      ack_q <= ack_d;
      ack_cnt_q <= ack_cnt_d;
      ack_per_q <= ack_per_d;
      unlocked_q <= unlocked_d;
    end
  end

  // ==========================================================
  // outputs
  // open drain: the pin only ever pulls low
  assign LINK.ack_out = 1'b0;
  assign LINK.ack_oe = ack_q;
  assign DAC_CODE = code_q;
  assign FAULT_FLAG = err_q;
  assign INPUT_ECHO = din_q;
  assign CFG_UNLOCKED = unlocked_q;

endmodule : swr_device

// >>> rtl/swr_defs.svh
// Purpose: shared constants for the single-wire symbol link
// Assumes: 20 MHz clock on both ends
// Notes: offsets, field positions, reset values, timing counts
`ifndef SWR_DEFS_SVH
`define SWR_DEFS_SVH

// ==========================================================
// clock and symbol timing
`define SWR_CLK_HZ 20000000
`define SWR_RATE_MIN_HZ 300
`define SWR_RATE_MAX_HZ 19200
`define SWR_PER_MIN_CYC (`SWR_CLK_HZ / `SWR_RATE_MAX_HZ)
`define SWR_PER_MAX_CYC (`SWR_CLK_HZ / `SWR_RATE_MIN_HZ)
`define SWR_TIMEOUT_MS 100
`define SWR_TIMEOUT_CYC ((`SWR_CLK_HZ / 1000) * `SWR_TIMEOUT_MS)

// ==========================================================
// high-time bands and ack delays in sixteenths of the period
`define SWR_DELIM_LO 7
`define SWR_DELIM_HI 9
`define SWR_ZERO_LO 3
`define SWR_ZERO_HI 5
`define SWR_ONE_LO 11
`define SWR_ONE_HI 13
`define SWR_ACK_ON_16THS 4
`define SWR_ACK_OFF_16THS 28

// ==========================================================
// frame layout: 24 bits, msb first
`define SWR_FRAME_BITS 24
`define SWR_KEY 8'h95
`define SWR_REG_LOCK 8'h00
`define SWR_REG_CFG1 8'h01
`define SWR_REG_CFG2 8'h02
`define SWR_REG_CODE 8'h10
`define SWR_LOCK_RST 8'h00
`define SWR_CFG2_RST 5'h1f
`define SWR_CODE_RST 16'h0000
`define SWR_CFG1_RST_BIT 0
`define SWR_CFG1_SERR_LSB 3
`define SWR_SERR_SET 2'h1
`define SWR_SERR_CLR 2'h2
`define SWR_CFG2_ACK_EN_BIT 4
`define SWR_CFG2_CHAN_BIT 1

// ==========================================================
// host controller apb map
`define SWR_HOST_TX 8'h00
`define SWR_HOST_PER 8'h04
`define SWR_HOST_STAT 8'h08
`define SWR_HOST_PER_RST 18'h007d0
`define SWR_STAT_BUSY_BIT 0
`define SWR_STAT_ACK_BIT 1

`endif

// >>> rtl/swr_pkg.sv
// Purpose: types shared by both ends of the symbol link
// Assumes: nothing
// Notes: one-hot encodings
package swr_pkg;
  typedef enum logic [1:0] {RX_HUNT = 2'b01, RX_BITS = 2'b10} swr_rx_state_t;
  typedef enum logic [2:0] {TX_IDLE = 3'b001, TX_SYM = 3'b010, TX_TAIL = 3'b100} swr_tx_state_t;
  typedef enum logic [3:0] {
    SYM_NONE = 4'b0001,
    SYM_DELIM = 4'b0010,
    SYM_ZERO = 4'b0100,
    SYM_ONE = 4'b1000
  } swr_sym_t;
endpackage : swr_pkg

// >>> rtl/swr_link_if.sv
// Purpose: single-wire data line plus open-drain acknowledge
// Assumes: pull-up on the acknowledge wire
// Notes: ack_level low means acknowledge asserted
`timescale 1ns/1ps
interface swr_link_if;
  logic line;
  logic ack_out;
  logic ack_oe;
  logic ack_level;

  // open drain: wire low only while the device enables its driver
  assign ack_level = ack_oe ? ack_out : 1'b1;

  modport host (output line, input ack_level);
  modport dev (input line, output ack_out, output ack_oe);
endinterface : swr_link_if

// >>> rtl/swr_host.sv
// Purpose: host controller sending framed symbols on the single wire
// Assumes: software programs a period within the accepted rate range
// Notes: apb slave, zero wait states, registered answers
`timescale 1ns/1ps
`include "swr_defs.svh"
module swr_host (
  input wire logic MCLK, // 20 MHz clock
  input wire logic ARST_N, // async reset, active low
  input wire logic PSEL, // apb select
  input wire logic PENABLE, // apb enable
  input wire logic PWRITE, // apb direction
  input wire logic [7:0] PADDR, // apb byte address
  input wire logic [31:0] PWDATA, // apb write data
  output logic [31:0] PRDATA, // apb read data
  output logic PREADY, // apb ready
  output logic PSLVERR, // apb error
  swr_link_if.host LINK // symbol line and ack
);

  // ==========================================================
  // state
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic [23:0] tx_q, tx_d;
  logic [17:0] per_q, per_d;
  swr_pkg::swr_tx_state_t state_q, state_d;
  logic [4:0] idx_q, idx_d;
  logic [17:0] cyc_q, cyc_d;
  logic line_q, line_d;
  logic [2:0] async_q, async_d;
  logic ack_f_q, ack_f_d;
  logic ack_seen_q, ack_seen_d;

  logic setup;
  logic access;
  logic mapped;
  logic busy;
  logic [17:0] hi_cyc;

  // ==========================================================
  // next-state logic
  always_comb begin
    setup = PSEL & ~PENABLE;
    access = PSEL & PENABLE & pready_q;
    busy = (state_q != swr_pkg::TX_IDLE);
    mapped = (PADDR == `SWR_HOST_TX) || (PADDR == `SWR_HOST_PER) || (PADDR == `SWR_HOST_STAT);

    // answer prepared in the setup cycle so every apb output is a flop
    pready_d = setup;
    pslverr_d = setup & ~mapped;
    prdata_d = 32'h00000000;
    if (setup && !PWRITE) begin
      case (PADDR)
        `SWR_HOST_TX: prdata_d = {8'h00, tx_q};
        `SWR_HOST_PER: prdata_d = {14'h0000, per_q};
        `SWR_HOST_STAT: prdata_d = {30'h00000000, ack_seen_q, busy};
        default: prdata_d = 32'h00000000;
      endcase
    end

    async_d = {async_q[1:0], LINK.ack_level};
    ack_f_d = (async_q[1] == async_q[2]) ? async_q[2] : ack_f_q;

    tx_d = tx_q;
    per_d = per_q;
    state_d = state_q;
    idx_d = idx_q;
    cyc_d = cyc_q;
    ack_seen_d = ack_seen_q;

    // delimiter for slots 0 and 25, data bits msb first between them
    if (idx_q == 5'h00 || idx_q == 5'(`SWR_FRAME_BITS + 1)) begin
      hi_cyc = {1'b0, per_q[17:1]};
    end else if (tx_q[5'(`SWR_FRAME_BITS) - idx_q]) begin
      hi_cyc = per_q - {2'h0, per_q[17:2]};
    end else begin
      hi_cyc = {2'h0, per_q[17:2]};
    end

    case (state_q)
      swr_pkg::TX_IDLE: begin
        cyc_d = 18'h00000;
        idx_d = 5'h00;
      end
      swr_pkg::TX_SYM: begin
        cyc_d = cyc_q + 18'h00001;
        if (cyc_q == per_q - 18'h00001) begin
          cyc_d = 18'h00000;
          idx_d = idx_q + 5'h01;
          if (idx_q == 5'(`SWR_FRAME_BITS + 1)) begin
            state_d = swr_pkg::TX_TAIL;
          end
        end
      end
      swr_pkg::TX_TAIL: begin
        // listen two periods past the closing delimiter for the ack window
        cyc_d = cyc_q + 18'h00001;
        if (!ack_f_q) begin
          ack_seen_d = 1'b1;
        end
        if (cyc_q == {per_q[16:0], 1'b0}) begin
          state_d = swr_pkg::TX_IDLE;
        end
      end
      default: begin
        state_d = swr_pkg::TX_IDLE;
      end
    endcase
    line_d = (state_q == swr_pkg::TX_SYM) && (cyc_q < hi_cyc);

    if (access && PWRITE) begin
      if (PADDR == `SWR_HOST_TX && !busy) begin
        tx_d = PWDATA[23:0];
        state_d = swr_pkg::TX_SYM;
        idx_d = 5'h00;
        cyc_d = 18'h00000;
        ack_seen_d = 1'b0;
      end
      if (PADDR == `SWR_HOST_PER && !busy) begin
        per_d = PWDATA[17:0];
      end
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
      tx_q <= 24'h000000;
      per_q <= `SWR_HOST_PER_RST;
      state_q <= swr_pkg::TX_IDLE;
      idx_q <= 5'h00;
      cyc_q <= 18'h00000;
      line_q <= 1'b0;
      async_q <= 3'h7;
      ack_f_q <= 1'b1;
      ack_seen_q <= 1'b0;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
      tx_q <= tx_d;
      per_q <= per_d;
      state_q <= state_d;
      idx_q <= idx_d;
      cyc_q <= cyc_d;
      line_q <= line_d;
      async_q <= async_d;
      ack_f_q <= ack_f_d;
      ack_seen_q <= ack_seen_d;
    end
  end

  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign PRDATA = prdata_q;
  assign LINK.line = line_q;

endmodule : swr_host

// >>> verif/swr_link_props.sv
// Purpose: timing checks on the wire between host and device
// Assumes: host keeps one period for all symbols of a frame
// Notes: counters hold cycles since the last rising edge of the line
`timescale 1ns/1ps
module swr_link_props (
  input wire logic MCLK, // clock
  input wire logic ARST_N, // async reset, active low
  input wire logic line, // data line
  input wire logic ack_out, // ack drive value
  input wire logic ack_oe, // ack driver enable
  input wire logic ack_level // resolved ack wire
);
  // ==========================================================
  // edge tracking
  logic line_q;
  logic rise;
  logic [31:0] cnt_q, cnt_d, hi_q, hi_d, per_q, per_d;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!ARST_N);

  assign rise = line && !line_q;

  always_comb begin
    cnt_d = rise ? 32'h1 : cnt_q + 32'h1;
    hi_d = rise ? 32'h1 : hi_q + {31'h0, line};
    per_d = rise ? cnt_q : per_q;
  end

  // large start value so the first rise is never taken as a period
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      line_q <= 1'b0;
      cnt_q <= 32'h00ff_ffff;
      hi_q <= 32'h0;
      per_q <= 32'h0;
    end else begin
      line_q <= line;
      cnt_q <= cnt_d;
      hi_q <= hi_d;
      per_q <= per_d;
    end
  end

  // ==========================================================
  // properties
  property p_ack_drive;
    ack_oe |-> !ack_out && !ack_level;
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("ack wire not pulled low");

  property p_ack_assert_win;
    $rose(ack_oe) |-> (cnt_q * 32'h10 >= per_q) && (cnt_q * 32'h2 <= per_q);
  endproperty
  a_ack_assert_win: assert property (p_ack_assert_win) else $error("ack assert delay");

  property p_ack_release_win;
    $fell(ack_oe) |-> (cnt_q * 32'h8 >= per_q * 32'hc) && (cnt_q * 32'h10 <= per_q * 32'h1f);
  endproperty
  a_ack_release_win: assert property (p_ack_release_win) else $error("ack release delay");

  property p_ack_hold;
    $rose(ack_oe) |=> ack_oe [*8];
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack pulse too short");

  property p_ack_in_delim;
    $rose(ack_oe) |-> line && (cnt_q < per_q);
  endproperty
  a_ack_in_delim: assert property (p_ack_in_delim) else $error("ack outside closing symbol");

  property p_release_idle;
    $fell(ack_oe) |-> !line;
  endproperty
  a_release_idle: assert property (p_release_idle) else $error("ack release during symbol");

  property p_sym_band;
    rise && (cnt_q == per_q) |->
      (hi_q * 32'h10 >= cnt_q * 32'h7 && hi_q * 32'h10 <= cnt_q * 32'h9) ||
      (hi_q * 32'h10 >= cnt_q * 32'h3 && hi_q * 32'h10 <= cnt_q * 32'h5) ||
      (hi_q * 32'h10 >= cnt_q * 32'hb && hi_q * 32'h10 <= cnt_q * 32'hd);
  endproperty
  a_sym_band: assert property (p_sym_band) else $error("symbol high time out of band");

  property p_rate;
    rise && (cnt_q < 32'h1046b) |-> cnt_q >= 32'h412;
  endproperty
  a_rate: assert property (p_rate) else $error("symbol rate too fast");
endmodule : swr_link_props

// >>> verif/tb_top.sv
// Purpose: host and device joined on one wire, driven over apb
// Assumes: fastest legal symbol period keeps the run short
// Notes: timer shortened, still longer than one frame gap
`timescale 1ns/1ps
`include "swr_defs.svh"
module tb_top;
  localparam int unsigned TMO_CYC = 30000;
  // 1042 cycles is the shortest period that stays at or below the top rate
  localparam logic [31:0] PER = 32'h0000_0412;
  logic MCLK = 1'b0;
  logic ARST_N = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err_q;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd_q;
  logic [15:0] dac_code;
  logic fault_flag, input_echo, cfg_unlocked;
  int error_cnt = 0;
  int cmp_count = 0;
  int ack_low = 0;

  swr_link_if link();
  swr_host i_swr_host (.MCLK(MCLK), .ARST_N(ARST_N), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .LINK(link));
  swr_device #(.TIMEOUT_CYC(TMO_CYC)) i_swr_device (.MCLK(MCLK), .ARST_N(ARST_N), .LINK(link),
    .DAC_CODE(dac_code), .FAULT_FLAG(fault_flag), .INPUT_ECHO(input_echo), .CFG_UNLOCKED(cfg_unlocked));
  swr_link_props i_swr_link_props (.MCLK(MCLK), .ARST_N(ARST_N), .line(link.line), .ack_out(link.ack_out),
    .ack_oe(link.ack_oe), .ack_level(link.ack_level));

  always #25 MCLK = ~MCLK;
  always @(posedge MCLK) if (!link.ack_level) ack_low <= ack_low + 1;

  // ==========================================================
  // shared tasks
  task automatic finish_test;
    $display("checks %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    int n;
    @(posedge MCLK);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge MCLK);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge MCLK);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      check("pready", 32'h0, 32'h1);
      finish_test();
    end
  endtask : apb

  // whole frame, then the ack seen by the host and the ack width on the wire
  task automatic send_frame(input logic [23:0] word);
    int n;
    ack_low = 0;
    apb(1'b1, `SWR_HOST_TX, {8'h00, word});
    // opening delimiter is high by now, past the three-flop filter
    repeat (8) @(posedge MCLK);
    check("echo_hi", {31'h0, input_echo}, 32'h1);
    n = 0;
    do begin
      apb(1'b0, `SWR_HOST_STAT, 32'h0);
      n++;
    end while (rd_q[0] !== 1'b0 && n < 12000);
    if (n >= 12000) begin
      check("busy", 32'h1, 32'h0);
      finish_test();
    end
    check("ack_seen", {31'h0, rd_q[1]}, 32'h1);
    check("ack_width", ack_low, PER * 28 / 16 - PER * 4 / 16);
  endtask : send_frame

  // ==========================================================
  // scenarios
  task automatic t_reset;
    check("dac", {16'h0, dac_code}, 32'h0);
    check("fault", {31'h0, fault_flag}, 32'h1);
    check("unlocked", {31'h0, cfg_unlocked}, 32'h0);
    check("echo", {31'h0, input_echo}, 32'h0);
    check("ack_idle", {31'h0, link.ack_level}, 32'h1);
    apb(1'b0, `SWR_HOST_PER, 32'h0);
    check("per_rst", rd_q, 32'h7d0);
    apb(1'b0, 8'h0c, 32'h0);
    check("unmapped_err", {31'h0, err_q}, 32'h1);
    check("unmapped_data", rd_q, 32'h0);
    apb(1'b1, `SWR_HOST_PER, PER);
    apb(1'b0, `SWR_HOST_PER, 32'h0);
    check("per", rd_q, PER);
  endtask : t_reset

  task automatic t_code_locked;
    send_frame(24'h10_1234);
    check("dac", {16'h0, dac_code}, 32'h1234);
    check("fault", {31'h0, fault_flag}, 32'h0);
  endtask : t_code_locked

  task automatic t_unlock;
    send_frame({`SWR_REG_LOCK, 8'h00, `SWR_KEY});
    check("unlocked", {31'h0, cfg_unlocked}, 32'h1);
  endtask : t_unlock

  task automatic t_code_unlocked;
    send_frame(24'h10_5678);
    check("dac", {16'h0, dac_code}, 32'h1234);
    check("unlocked", {31'h0, cfg_unlocked}, 32'h1);
  endtask : t_code_unlocked

  // timer runs from the last valid frame: closing symbol plus host tail, about 3 periods before the wait
  task automatic t_timeout;
    int n;
    n = 0;
    while (fault_flag !== 1'b1 && n < TMO_CYC) begin
      @(posedge MCLK);
      n++;
    end
    check("fault", {31'h0, fault_flag}, 32'h1);
    check("tmo_span", {31'h0, (n > TMO_CYC - 4 * PER) && (n < TMO_CYC - 2 * PER)}, 32'h1);
  endtask : t_timeout

  initial begin
    repeat (6) @(posedge MCLK);
    ARST_N <= 1'b1;
    @(posedge MCLK);
    t_reset();
    t_code_locked();
    t_unlock();
    t_code_unlocked();
    t_timeout();
    finish_test();
  end
endmodule : tb_top
